// >>> logic/tcu_core.sv
// Purpose: 16-bit timer core with prescaler, repetition and update logic
// Assumes: psc_tick and slave_update come from logic on aclk
// Notes: AXI4-Lite slave, one write and one read in flight
`timescale 1ns/1ns
`include "tcu_regs.svh"

module tcu_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic psc_tick,
	input wire logic slave_update,
	output logic irq,
	output logic update_event,
	output logic [15:0] count_value,
	output logic count_dir
);

	tcu_pkg::tcu_state_t st_reg;
	tcu_pkg::tcu_state_t st_next;
	logic wr_go;
	logic rd_go;
	logic tick;
	logic force_upd;
	logic edge_mode;

	// ************************************************************
	// register image and byte-lane merge
	// ************************************************************
	// returns {mapped, data} for one aligned word
	function automatic logic [32:0] tcu_image(tcu_pkg::tcu_state_t s, logic [7:0] a);
		logic [31:0] d;
		logic ok;
		d = 32'h0;
		ok = 1'b1;
		case (a)
			`TCU_OFF_CTRL: begin
				d[`TCU_CTRL_EN] = s.en;
				d[`TCU_CTRL_UPDATE_INHIBIT] = s.update_inhibit;
				d[`TCU_CTRL_URS] = s.update_source_select;
				d[`TCU_CTRL_DIR] = s.dir;
				d[`TCU_CTRL_ALIGN +: 2] = s.align;
			end
			`TCU_OFF_MASK: d[1:0] = s.mask;
			`TCU_OFF_FLAG: d[1:0] = s.flags;
			`TCU_OFF_TRIG: d = 32'h0;
			`TCU_OFF_CNT: d[15:0] = s.cnt;
			`TCU_OFF_PSC: d[15:0] = s.psc_pre;
			`TCU_OFF_ARR: d[15:0] = s.arr_pre;
			`TCU_OFF_REP: d[7:0] = s.rep_pre;
			`TCU_OFF_CMP: d[15:0] = s.cmp;
			default: ok = 1'b0;
		endcase
		return {ok, d};
	endfunction

	function automatic logic [31:0] tcu_merge(logic [31:0] o, logic [31:0] n, logic [3:0] be);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = n[8*i +: 8];
			end
		end
		return m;
	endfunction

	// ************************************************************
	// control terms
	// ************************************************************
	// write needs both halves and a free response slot
	assign wr_go = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
	assign rd_go = s_axi_arvalid && st_reg.arready;
	assign edge_mode = (st_reg.align == tcu_pkg::TCU_EDGE);
	// one counter step per psc_act+1 input ticks
	assign tick = st_reg.en && psc_tick && (st_reg.psc_cnt == st_reg.psc_act);
	// software trigger write or slave controller both force
	assign force_upd = slave_update || (wr_go && st_reg.awaddr == `TCU_OFF_TRIG &&
		st_reg.wstrb[0] && st_reg.wdata[`TCU_TRIG_UG]);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [31:0] wd;
		logic [32:0] img;
		logic do_upd;
		logic set_upd;
		logic wrap;
		logic up_now;
		wd = 32'h0;
		img = 33'h0;
		do_upd = 1'b0;
		set_upd = 1'b0;
		wrap = 1'b0;
		up_now = !st_reg.dir;
		st_next = st_reg;
		st_next.upd_pulse = 1'b0;

		// axi channel capture
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_full = 1'b1;
			st_next.awaddr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_full = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// register writes; clears come before hardware sets
		if (wr_go) begin
			img = tcu_image(st_reg, st_reg.awaddr);
			wd = tcu_merge(img[31:0], st_reg.wdata, st_reg.wstrb);
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = img[32] ? tcu_pkg::TCU_OKAY : tcu_pkg::TCU_SLVERR;
			case (st_reg.awaddr)
				`TCU_OFF_CTRL: begin
					st_next.en = wd[`TCU_CTRL_EN];
					st_next.update_inhibit = wd[`TCU_CTRL_UPDATE_INHIBIT];
					st_next.update_source_select = wd[`TCU_CTRL_URS];
					st_next.align = tcu_pkg::tcu_align_t'(wd[`TCU_CTRL_ALIGN +: 2]);
					// direction only follows software in edge mode
					if (wd[`TCU_CTRL_ALIGN +: 2] == 2'b00) begin
						st_next.dir = wd[`TCU_CTRL_DIR];
					end
				end
				`TCU_OFF_MASK: st_next.mask = wd[1:0];
				`TCU_OFF_FLAG: begin
					if (st_reg.wstrb[0]) begin
						st_next.flags = st_reg.flags & ~st_reg.wdata[1:0];
					end
				end
				`TCU_OFF_CNT: st_next.cnt = wd[15:0];
				`TCU_OFF_PSC: st_next.psc_pre = wd[15:0];
				`TCU_OFF_ARR: st_next.arr_pre = wd[15:0];
				`TCU_OFF_REP: st_next.rep_pre = wd[7:0];
				`TCU_OFF_CMP: st_next.cmp = wd[15:0];
				default: st_next.bresp = img[32] ? tcu_pkg::TCU_OKAY : tcu_pkg::TCU_SLVERR;
			endcase
		end

		// counter: a forced update beats a counting step
		if (force_upd) begin
			st_next.psc_cnt = 16'h0;
			if (edge_mode && st_reg.dir) begin
				st_next.cnt = st_reg.update_inhibit ? st_reg.arr_act : st_reg.arr_pre;
			end else begin
				st_next.cnt = 16'h0;
			end
			if (!edge_mode) begin
				st_next.dir = 1'b0;
			end
			if (!st_reg.update_inhibit) begin
				do_upd = 1'b1;
				set_upd = !st_reg.update_source_select;
			end
		end else if (tick) begin
			st_next.psc_cnt = 16'h0;
			if (edge_mode && !st_reg.dir) begin
				if (st_reg.cnt == st_reg.arr_act) begin
					st_next.cnt = 16'h0;
					wrap = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + 16'h1;
				end
			end else if (edge_mode) begin
				if (st_reg.cnt == 16'h0) begin
					wrap = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h1;
				end
			end else if (!st_reg.dir) begin
				// center rising half turns at reload-1, active value only
				if ({1'b0, st_reg.cnt} + 17'h1 >= {1'b0, st_reg.arr_act}) begin
					st_next.cnt = st_reg.arr_act;
					st_next.dir = 1'b1;
					wrap = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + 16'h1;
				end
			end else begin
				if (st_reg.cnt <= 16'h1) begin
					st_next.cnt = 16'h0;
					st_next.dir = 1'b0;
					wrap = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt - 16'h1;
				end
			end
			// repetition gating of the wrap
			if (wrap) begin
				if (st_reg.rep_cnt != 8'h0) begin
					st_next.rep_cnt = st_reg.rep_cnt - 8'h1;
				end else if (!st_reg.update_inhibit) begin
					do_upd = 1'b1;
					set_upd = 1'b1;
				end
			end
			// down reload picks up the period loaded on this very update
			if (wrap && edge_mode && st_reg.dir) begin
				st_next.cnt = do_upd ? st_reg.arr_pre : st_reg.arr_act;
			end
			// compare flag direction filter
			if (st_reg.cnt == st_reg.cmp) begin
				case (st_reg.align)
					tcu_pkg::TCU_CTR_DOWN: st_next.flags[`TCU_FLAG_CMP] |= !up_now;
					tcu_pkg::TCU_CTR_UP: st_next.flags[`TCU_FLAG_CMP] |= up_now;
					default: st_next.flags[`TCU_FLAG_CMP] = 1'b1;
				endcase
			end
		end else if (st_reg.en && psc_tick) begin
			st_next.psc_cnt = st_reg.psc_cnt + 16'h1;
		end

		// shadow loads on every update event
		if (do_upd) begin
			st_next.arr_act = st_reg.arr_pre;
			st_next.psc_act = st_reg.psc_pre;
			st_next.rep_cnt = st_reg.rep_pre;
			st_next.upd_pulse = 1'b1;
		end
		if (set_upd) begin
			st_next.flags[`TCU_FLAG_UPD] = 1'b1;
		end

		// read channel
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			img = tcu_image(st_reg, {s_axi_araddr[7:2], 2'b00});
			st_next.rvalid = 1'b1;
			st_next.rdata = img[31:0];
			st_next.rresp = img[32] ? tcu_pkg::TCU_OKAY : tcu_pkg::TCU_SLVERR;
		end
		st_next.awready = !st_next.aw_full && !st_next.bvalid;
		st_next.wready = !st_next.w_full && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
		st_next.irq = |(st_next.flags & st_next.mask);

		// synchronous reset
		if (!aresetn) begin
			st_next = '0;
			st_next.arr_pre = `TCU_ARR_RST;
			st_next.arr_act = `TCU_ARR_RST;
			st_next.psc_pre = `TCU_PSC_RST;
			st_next.psc_act = `TCU_PSC_RST;
			st_next.rep_pre = `TCU_REP_RST;
			st_next.rep_cnt = `TCU_REP_RST;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
			st_next.arready = 1'b1;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

	// outputs straight from state flops
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign irq = st_reg.irq;
	assign update_event = st_reg.upd_pulse;
	assign count_value = st_reg.cnt;
	assign count_dir = st_reg.dir;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_up_wrap_zero: assert property (tick && !force_upd && edge_mode && !st_reg.dir &&
		st_reg.cnt == st_reg.arr_act |=> st_reg.cnt == 16'h0)
		else $error("up counter did not wrap to zero");
	a_rep_gates_update: assert property (tick && !force_upd && st_reg.rep_cnt != 8'h0
		|=> !st_reg.upd_pulse)
		else $error("update issued while repeat count pending");
	a_inhibit_no_update: assert property (st_reg.update_inhibit |=> !st_reg.upd_pulse)
		else $error("update issued while inhibited");
	a_force_up_restart: assert property (force_upd && edge_mode && !st_reg.dir
		|=> st_reg.cnt == 16'h0 && st_reg.psc_cnt == 16'h0)
		else $error("forced update did not restart up counter");
	a_urs_hides_flag: assert property (force_upd && st_reg.update_source_select &&
		!st_reg.flags[`TCU_FLAG_UPD] |=> !st_reg.flags[`TCU_FLAG_UPD])
		else $error("update flag set by hidden forced update");
	a_update_loads: assert property (st_reg.upd_pulse |-> st_reg.arr_act == $past(st_reg.arr_pre)
		&& st_reg.psc_act == $past(st_reg.psc_pre) && st_reg.rep_cnt == $past(st_reg.rep_pre))
		else $error("update did not load active registers");
	a_down_reload: assert property (tick && !force_upd && edge_mode && st_reg.dir &&
		st_reg.cnt == 16'h0 && st_reg.rep_cnt == 8'h0 && !st_reg.update_inhibit
		|=> st_reg.cnt == st_reg.arr_act)
		else $error("down counter did not reload new period");
	a_center_turn: assert property (tick && !force_upd && !edge_mode && !st_reg.dir &&
		st_reg.arr_act != 16'h0 && st_reg.cnt == st_reg.arr_act - 16'h1
		|=> st_reg.dir && st_reg.cnt == $past(st_reg.arr_act))
		else $error("center counter did not turn at reload");
	a_psc_restart: assert property (tick && !force_upd |=> st_reg.psc_cnt == 16'h0)
		else $error("prescaler count did not restart");
	// a write to the flag or the mask may drop the level on purpose
	a_irq_follow: assert property (st_reg.flags[`TCU_FLAG_UPD] && st_reg.mask[0]
		&& !(wr_go && st_reg.awaddr == `TCU_OFF_FLAG)
		&& !(wr_go && st_reg.awaddr == `TCU_OFF_MASK) |=> irq)
		else $error("interrupt not raised for pending flag");

	// direction, compare filter, repeat, forced update and inhibit checks; control writes are left out
	// because a write that picks edge mode may load the direction bit
	a_dir_hw_owned: assert property (!edge_mode && !tick && !force_upd && !wr_go
		|=> $stable(st_reg.dir))
		else $error("direction changed outside a center turn");
	a_center_bottom: assert property (tick && !force_upd && !edge_mode && st_reg.dir &&
		st_reg.cnt == 16'h1 |=> !st_reg.dir && st_reg.cnt == 16'h0)
		else $error("center counter did not turn at one");
	a_cmp_down_only: assert property (tick && !force_upd && !st_reg.dir &&
		st_reg.align == tcu_pkg::TCU_CTR_DOWN && !st_reg.flags[`TCU_FLAG_CMP]
		|=> !st_reg.flags[`TCU_FLAG_CMP])
		else $error("compare flag set while counting up in align 01");
	a_cmp_up_only: assert property (tick && !force_upd && st_reg.dir &&
		st_reg.align == tcu_pkg::TCU_CTR_UP && !st_reg.flags[`TCU_FLAG_CMP]
		|=> !st_reg.flags[`TCU_FLAG_CMP])
		else $error("compare flag set while counting down in align 10");
	a_cmp_both_set: assert property (tick && !force_upd && st_reg.cnt == st_reg.cmp &&
		(st_reg.align == tcu_pkg::TCU_EDGE || st_reg.align == tcu_pkg::TCU_CTR_BOTH)
		|=> st_reg.flags[`TCU_FLAG_CMP])
		else $error("compare flag missed on match");
	a_rep_zero_update: assert property (tick && !force_upd && edge_mode && !st_reg.dir &&
		st_reg.cnt == st_reg.arr_act && st_reg.rep_cnt == 8'h0 && !st_reg.update_inhibit
		|=> st_reg.upd_pulse && st_reg.flags[`TCU_FLAG_UPD])
		else $error("overflow without repeat did not update");
	a_force_sets_flag: assert property (force_upd && !st_reg.update_inhibit && !st_reg.update_source_select
		|=> st_reg.upd_pulse && st_reg.flags[`TCU_FLAG_UPD])
		else $error("forced update did not update");
	a_down_force: assert property (force_upd && edge_mode && st_reg.dir && !st_reg.update_inhibit
		|=> st_reg.cnt == st_reg.arr_act && st_reg.psc_cnt == 16'h0)
		else $error("forced update did not restart down counter");
	a_inhibit_holds: assert property (st_reg.update_inhibit
		|=> $stable(st_reg.arr_act) && $stable(st_reg.psc_act))
		else $error("active values changed while inhibited");
	a_center_force: assert property (force_upd && !edge_mode
		|=> st_reg.cnt == 16'h0 && st_reg.psc_cnt == 16'h0 && !st_reg.dir)
		else $error("forced update did not restart center counter");

	c_up_update: cover property (edge_mode && !st_reg.dir && st_reg.upd_pulse);
	c_center_both: cover property (!edge_mode && st_reg.dir ##[1:200] !st_reg.dir);
	c_forced_hidden: cover property (force_upd && st_reg.update_source_select && !st_reg.update_inhibit);
	c_rep_skip: cover property (tick && st_reg.rep_cnt != 8'h0);
	c_cmp_down: cover property (tick && st_reg.align == tcu_pkg::TCU_CTR_DOWN &&
		st_reg.dir && st_reg.cnt == st_reg.cmp);

endmodule

// >>> logic/tcu_regs.svh
// Purpose: register offsets, field positions and reset values of the timer count core
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address, one aligned word per register
// Notes: included by bare name; definitions only
// Contract
// - up mode counts zero to reload, wraps
// - repeat counter gates update every value+1 wraps
// - repeat value zero updates on every wrap
// - force update bit or trigger issues update
// - inhibit blocks updates and shadow copies
// - up mode force restarts counter and prescaler
// - source select hides flag on forced update
// - update reloads repeat, reload, prescale, flag
// - down mode counts reload to zero, reloads
// - down mode force restarts from reload value
// - new reload active before counter reloads
// - center mode up to reload, down to zero
// - align field selects compare flag directions
// - center mode direction owned by hardware
// - center mode updates at both turns
// - inhibited center mode keeps active reload
// - prescaler divides by value+1 after update
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define TCU_OFF_CTRL 8'h00
`define TCU_OFF_MASK 8'h04
`define TCU_OFF_FLAG 8'h08
`define TCU_OFF_TRIG 8'h0c
`define TCU_OFF_CNT 8'h10
`define TCU_OFF_PSC 8'h14
`define TCU_OFF_ARR 8'h18
`define TCU_OFF_REP 8'h1c
`define TCU_OFF_CMP 8'h20

// ************************************************************
// field positions
// ************************************************************
`define TCU_CTRL_EN 0
`define TCU_CTRL_UPDATE_INHIBIT 1
`define TCU_CTRL_URS 2
`define TCU_CTRL_DIR 4
`define TCU_CTRL_ALIGN 5
`define TCU_FLAG_UPD 0
`define TCU_FLAG_CMP 1
`define TCU_TRIG_UG 0

// ************************************************************
// reset values
// ************************************************************
`define TCU_ARR_RST 16'hffff
`define TCU_PSC_RST 16'h0000
`define TCU_REP_RST 8'h00

`endif

// >>> logic/tcu_pkg.sv
// Purpose: types shared by the timer count core
// Assumes: used through tcu_pkg:: scoped names only
// Notes: the whole module state is one packed struct
package tcu_pkg;

	// counter alignment modes
	typedef enum logic [1:0] {
		TCU_EDGE = 2'b00,
		TCU_CTR_DOWN = 2'b01,
		TCU_CTR_UP = 2'b10,
		TCU_CTR_BOTH = 2'b11
	} tcu_align_t;

	// axi response codes
	typedef enum logic [1:0] {
		TCU_OKAY = 2'b00,
		TCU_SLVERR = 2'b10
	} tcu_resp_t;

	typedef struct packed {
		logic [7:0] awaddr;
		logic aw_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_full;
		logic awready;
		logic wready;
		logic bvalid;
		tcu_resp_t bresp;
		logic arready;
		logic rvalid;
		tcu_resp_t rresp;
		logic [31:0] rdata;
		logic en;
		logic update_inhibit;
		logic update_source_select;
		logic dir;
		tcu_align_t align;
		logic [1:0] mask;
		logic [1:0] flags;
		logic [15:0] cnt;
		logic [15:0] psc_pre;
		logic [15:0] psc_act;
		logic [15:0] psc_cnt;
		logic [15:0] arr_pre;
		logic [15:0] arr_act;
		logic [7:0] rep_pre;
		logic [7:0] rep_cnt;
		logic [15:0] cmp;
		logic irq;
		logic upd_pulse;
	} tcu_state_t;

endpackage

// >>> dv/test_timer_count_core_update_logic.sv
// Purpose: self-checking bench for the timer count core
// Assumes: psc_tick pulsed by hand, so one pulse is one step while prescale is zero
// Notes: registers are reached through AXI4-Lite tasks; the update pulse is counted in ue
`timescale 1ns/1ns
`include "tcu_regs.svh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module test_timer_count_core_update_logic;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic psc_tick = 1'b0;
	logic slave_update = 1'b0;
	logic irq;
	logic update_event;
	logic [15:0] count_value;
	logic count_dir;
	int err_count = 0;
	int n_checks = 0;
	int ue = 0;
	logic [1:0] br;
	logic [1:0] rr;
	logic [31:0] rd_data;

	tcu_core tcu_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .psc_tick(psc_tick), .slave_update(slave_update),
		.irq(irq), .update_event(update_event), .count_value(count_value),
		.count_dir(count_dir));

	// 50 MHz clock
	always #10 aclk = ~aclk;

	// update pulses are tallied here so steps need not align to them
	always @(posedge aclk) begin
		if (update_event === 1'b1)
			ue++;
	end

	// ************************************************************
	// bus tasks and helpers
	// ************************************************************
	task wrap_up;
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				br = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (i == 40) begin
			err_count++;
			wrap_up();
		end
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_data = s_axi_rdata;
				rr = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (i == 40) begin
			err_count++;
			wrap_up();
		end
	endtask

	// one prescaler input pulse, then let the count settle
	task automatic stepc(input logic [15:0] e);
		@(posedge aclk);
		psc_tick <= 1'b1;
		@(posedge aclk);
		psc_tick <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK("count_value", e, count_value)
	endtask

	// one extra edge so the update pulse is tallied before callers reset the tally
	task automatic force_upd;
		wr(`TCU_OFF_TRIG, 32'h1);
		@(posedge aclk);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic up_mode;
		wr(`TCU_OFF_ARR, 32'h2);
		wr(`TCU_OFF_CTRL, 32'h1);
		force_upd();
		`CHK("count after force", 16'h0, count_value)
		rd(`TCU_OFF_FLAG);
		`CHK("flag after force", 1'b1, rd_data[0])
		wr(`TCU_OFF_FLAG, 32'h1);
		rd(`TCU_OFF_FLAG);
		`CHK("flag cleared", 1'b0, rd_data[0])
		ue = 0;
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h0);
		`CHK("updates per wrap", 1, ue)
		wr(`TCU_OFF_ARR, 32'h1);
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h0);
		stepc(16'h1);
		stepc(16'h0);
		`CHK("updates two wraps", 3, ue)
	endtask

	task automatic repeat_gate;
		wr(`TCU_OFF_REP, 32'h2);
		force_upd();
		ue = 0;
		repeat (2) begin
			stepc(16'h1);
			stepc(16'h0);
		end
		`CHK("no update before third wrap", 0, ue)
		stepc(16'h1);
		stepc(16'h0);
		`CHK("update at third wrap", 1, ue)
		wr(`TCU_OFF_REP, 32'h0);
		force_upd();
	endtask

	task automatic forced_paths;
		stepc(16'h1);
		wr(`TCU_OFF_CTRL, 32'h5);
		wr(`TCU_OFF_FLAG, 32'h1);
		ue = 0;
		force_upd();
		repeat (2) @(posedge aclk);
		`CHK("count after quiet force", 16'h0, count_value)
		`CHK("quiet force pulse", 1, ue)
		rd(`TCU_OFF_FLAG);
		`CHK("flag held clear", 1'b0, rd_data[0])
		stepc(16'h1);
		@(posedge aclk);
		slave_update <= 1'b1;
		@(posedge aclk);
		slave_update <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK("count after slave update", 16'h0, count_value)
		wr(`TCU_OFF_CTRL, 32'h1);
	endtask

	// new ratio waits for an update, then two pulses make one step
	task automatic prescale;
		wr(`TCU_OFF_PSC, 32'h1);
		stepc(16'h1);
		force_upd();
		stepc(16'h0);
		stepc(16'h1);
		wr(`TCU_OFF_PSC, 32'h0);
		force_upd();
	endtask

	task automatic inhibit;
		wr(`TCU_OFF_CTRL, 32'h3);
		wr(`TCU_OFF_ARR, 32'h3);
		ue = 0;
		stepc(16'h1);
		force_upd();
		`CHK("inhibited force restart", 16'h0, count_value)
		stepc(16'h1);
		stepc(16'h0);
		`CHK("no update while inhibited", 0, ue)
		wr(`TCU_OFF_CTRL, 32'h1);
		stepc(16'h1);
		stepc(16'h0);
		`CHK("update after inhibit cleared", 1, ue)
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h3);
		force_upd();
	endtask

	task automatic center;
		wr(`TCU_OFF_CTRL, 32'h71);
		`CHK("dir write ignored", 1'b0, count_dir)
		force_upd();
		ue = 0;
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h3);
		`CHK("dir down at top", 1'b1, count_dir)
		stepc(16'h2);
		stepc(16'h1);
		stepc(16'h0);
		`CHK("dir up at bottom", 1'b0, count_dir)
		`CHK("updates both turns", 2, ue)
	endtask

	task automatic down_mode;
		wr(`TCU_OFF_CTRL, 32'h11);
		force_upd();
		`CHK("down force loads reload", 16'h3, count_value)
		`CHK("dir set by software", 1'b1, count_dir)
		ue = 0;
		stepc(16'h2);
		stepc(16'h1);
		stepc(16'h0);
		stepc(16'h3);
		`CHK("underflow update", 1, ue)
	endtask

	task automatic irq_and_bus;
		wr(`TCU_OFF_MASK, 32'h1);
		force_upd();
		repeat (2) @(posedge aclk);
		`CHK("irq raised", 1'b1, irq)
		wr(`TCU_OFF_FLAG, 32'h1);
		repeat (2) @(posedge aclk);
		`CHK("irq after clear", 1'b0, irq)
		force_upd();
		wr(`TCU_OFF_MASK, 32'h0);
		repeat (2) @(posedge aclk);
		`CHK("irq masked", 1'b0, irq)
		wr(8'h40, 32'h1);
		`CHK("unmapped write resp", 2'b10, br)
		rd(8'h40);
		`CHK("unmapped read resp", 2'b10, rr)
		`CHK("unmapped read data", 32'h0, rd_data)
	endtask

	// compare flag per direction, then inhibited center counting on the old period
	task automatic compare_dirs;
		wr(`TCU_OFF_CMP, 32'h2);
		`CHK("mapped write resp", 2'b00, br)
		wr(`TCU_OFF_CTRL, 32'h21);
		force_upd();
		wr(`TCU_OFF_FLAG, 32'h3);
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h3);
		rd(`TCU_OFF_FLAG);
		`CHK("compare flag rising align 01", 1'b0, rd_data[1])
		`CHK("mapped read resp", 2'b00, rr)
		stepc(16'h2);
		stepc(16'h1);
		rd(`TCU_OFF_FLAG);
		`CHK("compare flag falling align 01", 1'b1, rd_data[1])
		wr(`TCU_OFF_CTRL, 32'h41);
		force_upd();
		wr(`TCU_OFF_FLAG, 32'h3);
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h3);
		rd(`TCU_OFF_FLAG);
		`CHK("compare flag rising align 10", 1'b1, rd_data[1])
		wr(`TCU_OFF_FLAG, 32'h2);
		stepc(16'h2);
		stepc(16'h1);
		rd(`TCU_OFF_FLAG);
		`CHK("compare flag falling align 10", 1'b0, rd_data[1])
		wr(`TCU_OFF_ARR, 32'h5);
		wr(`TCU_OFF_CTRL, 32'h43);
		ue = 0;
		stepc(16'h0);
		stepc(16'h1);
		stepc(16'h2);
		stepc(16'h3);
		stepc(16'h2);
		`CHK("inhibited center dir", 1'b1, count_dir)
		`CHK("no update inhibited center", 0, ue)
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("count at reset", 16'h0, count_value)
		rd(`TCU_OFF_ARR);
		`CHK("reload reset", 32'h0000ffff, rd_data)
		up_mode();
		repeat_gate();
		forced_paths();
		prescale();
		inhibit();
		center();
		down_mode();
		irq_and_bus();
		compare_dirs();
		wrap_up();
	end
endmodule
